// >>> rtl/pmc_defs.svh
// Offsets, field positions, reset values and timing counts of the power control block
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

// Register offsets and endian check pattern
`define PMC_CTRL_OFFSET 8'h84
`define PMC_ENDIAN_OFFSET 8'h64
`define PMC_ENDIAN_PATTERN 32'h1357_9bdf

// Control register fields
`define PMC_STATE_MSB 13
`define PMC_STATE_LSB 12
`define PMC_PHY_RESET_TRIGGER_BIT 10
`define PMC_FRAME_EN_BIT 9
`define PMC_ENERGY_EN_BIT 8
`define PMC_DRIVE_TYPE_BIT 6
`define PMC_CAUSE_FRAME_BIT 5
`define PMC_CAUSE_ENERGY_BIT 4
`define PMC_PULSE_SEL_BIT 3
`define PMC_POLARITY_BIT 2
`define PMC_OUT_EN_BIT 1
`define PMC_READY_BIT 0

// Reset values
`define PMC_STATE_RESET 2'h0
`define PMC_BIT_RESET 1'h0

// Timing
`define PMC_CLK_PERIOD_NS 4
`define PMC_PHY_RESET_TRIGGER_US 100
`define PMC_PHY_RESET_TRIGGER_CYCLES ((`PMC_PHY_RESET_TRIGGER_US * 1000 + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS)
`define PMC_PULSE_MS 50
`define PMC_PULSE_CYCLES ((`PMC_PULSE_MS * 1000000) / `PMC_CLK_PERIOD_NS)
`define PMC_STABLE_CYCLES 1000
`define PMC_TIMER_W 24

`endif

// >>> rtl/pmc_pkg.sv
// Types of the power control block
package pmc_pkg;

  typedef enum logic [1:0] {
    full_power_state   = 2'b00,
    packet_wake_state  = 2'b01,
    energy_wake_state  = 2'b10,
    reserved_state     = 2'b11
  } pmc_state_t;

endpackage

// >>> rtl/pmc_cycle_timer.sv
// Down counter that runs a loaded number of cycles and flags the end
`timescale 1ns/100ps
module pmc_cycle_timer #(
  parameter int W = 24
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [W-1:0] load,
  output logic busy,
  output logic done
);

  logic [W-1:0] count;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      count <= '0;
      done <= 1'b0;
    end else if (start) begin
      count <= load;
      done <= 1'b0;
    end else begin
      if (count != '0) begin
        count <= count - 1'b1;
      end
      done <= (count == {{(W-1){1'b0}}, 1'b1});
    end
  end

  assign busy = (count != '0);

endmodule // pmc_cycle_timer

// >>> rtl/pmc_top.sv
// Power state control, wake detection and wake output driver
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
`include "pmc_defs.svh"
module pmc_top
  import pmc_pkg::*;
#(
  parameter int unsigned PHY_RESET_CYCLES = `PMC_PHY_RESET_TRIGGER_CYCLES,
  parameter int unsigned PULSE_CYCLES = `PMC_PULSE_CYCLES,
  parameter int unsigned STABLE_CYCLES = `PMC_STABLE_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic wake_frame_source,
  input wire logic energy_source,
  output logic wake_event_output,
  output logic wake_event_oe,
  output logic wake_event_interrupt,
  output logic phy_reset_n,
  output logic [1:0] power_state,
  output logic device_ready
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  pmc_state_t state;
  logic ready;
  logic unlocked;
  logic boot_pending;
  logic phy_reset_trigger;
  logic wake_frame_enable;
  logic energy_detect_enable;
  logic wake_output_drive_type;
  logic wake_pulse_select;
  logic wake_output_polarity;
  logic wake_output_enable;
  logic cause_frame;
  logic cause_energy;
  logic level_d;

  logic hit_ctrl;
  logic hit_endian;
  logic reduced;
  logic ctrl_wr;
  logic cause_wr_ok;
  logic endian_wake;
  logic event_wake;
  logic wake_req;
  logic phy_start;
  logic phy_done;
  logic pulse_start;
  logic pulse_busy;
  logic stable_start;
  logic stable_done;
  logic wake_level;
  logic wake_active;
  logic pin_active;
  logic [1:0] wr_state;
  logic [31:0] ctrl_value;
  logic next_cause_frame;
  logic next_cause_energy;

  ////////////////////////////////////////////////////////////////////////////
  // Access decode

  assign hit_ctrl = (reg_addr == `PMC_CTRL_OFFSET);
  assign hit_endian = (reg_addr == `PMC_ENDIAN_OFFSET);
  assign reduced = (state != full_power_state);
  assign wr_state = reg_wdata[`PMC_STATE_MSB:`PMC_STATE_LSB];

  // Control writes need the unlocking read and a ready device
  assign ctrl_wr = reg_wr && hit_ctrl && unlocked && ready;

  // Cause clears only in normal state with ready set
  assign cause_wr_ok = ctrl_wr && !reduced;

  // Any data written to the endian check register wakes the device
  assign endian_wake = reg_wr && hit_endian && reduced;

  // Enabled events wake from the matching reduced state
  assign event_wake = ((state == packet_wake_state) && wake_frame_source && wake_frame_enable)
                   || ((state == energy_wake_state) && energy_source && energy_detect_enable);

  assign wake_req = endian_wake || event_wake;

  ////////////////////////////////////////////////////////////////////////////
  // Read-before-write lock

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      unlocked <= 1'b0;
    end else if (wake_req) begin
      unlocked <= 1'b0;
    end else if (reg_rd) begin
      unlocked <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power state

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= pmc_state_t'(`PMC_STATE_RESET);
    end else if (wake_req) begin
      state <= full_power_state;
    end else if (ctrl_wr && wr_state != reserved_state) begin
      state <= pmc_state_t'(wr_state);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ready flag and stabilization

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      boot_pending <= 1'b1;
    end else begin
      boot_pending <= 1'b0;
    end
  end

  assign stable_start = boot_pending || wake_req;

  pmc_cycle_timer #(
    .W(`PMC_TIMER_W)
  ) u_stable_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(stable_start),
    .load(`PMC_TIMER_W'(STABLE_CYCLES)),
    .busy(),
    .done(stable_done)
  );

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ready <= 1'b0;
    end else if (stable_start) begin
      ready <= 1'b0;
    end else if (ctrl_wr && wr_state != reserved_state
                 && wr_state != full_power_state) begin
      ready <= 1'b0;
    end else if (stable_done && !reduced) begin
      ready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PHY reset

  // Writes to the bit are dropped while it is high
  assign phy_start = ctrl_wr && reg_wdata[`PMC_PHY_RESET_TRIGGER_BIT] && !phy_reset_trigger;

  pmc_cycle_timer #(
    .W(`PMC_TIMER_W)
  ) u_phy_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(phy_start),
    .load(`PMC_TIMER_W'(PHY_RESET_CYCLES)),
    .busy(),
    .done(phy_done)
  );

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      phy_reset_trigger <= `PMC_BIT_RESET;
      phy_reset_n <= 1'b1;
    end else if (phy_start) begin
      phy_reset_trigger <= 1'b1;
      phy_reset_n <= 1'b0;
    end else if (phy_done) begin
      phy_reset_trigger <= 1'b0;
      phy_reset_n <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration bits

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wake_frame_enable <= `PMC_BIT_RESET;
      energy_detect_enable <= `PMC_BIT_RESET;
      wake_output_drive_type <= `PMC_BIT_RESET;
      wake_pulse_select <= `PMC_BIT_RESET;
      wake_output_polarity <= `PMC_BIT_RESET;
      wake_output_enable <= `PMC_BIT_RESET;
    end else if (ctrl_wr) begin
      wake_frame_enable <= reg_wdata[`PMC_FRAME_EN_BIT];
      energy_detect_enable <= reg_wdata[`PMC_ENERGY_EN_BIT];
      wake_output_drive_type <= reg_wdata[`PMC_DRIVE_TYPE_BIT];
      wake_pulse_select <= reg_wdata[`PMC_PULSE_SEL_BIT];
      wake_output_polarity <= reg_wdata[`PMC_POLARITY_BIT];
      wake_output_enable <= reg_wdata[`PMC_OUT_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake cause, set wins over clear

  always_comb begin
    next_cause_frame = cause_frame;
    next_cause_energy = cause_energy;
    if (cause_wr_ok && reg_wdata[`PMC_CAUSE_FRAME_BIT] && !wake_frame_source) begin
      next_cause_frame = 1'b0;
    end
    if (cause_wr_ok && reg_wdata[`PMC_CAUSE_ENERGY_BIT] && !energy_source) begin
      next_cause_energy = 1'b0;
    end
    if (wake_frame_source && wake_frame_enable) begin
      next_cause_frame = 1'b1;
    end
    if (energy_source && energy_detect_enable) begin
      next_cause_energy = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cause_frame <= `PMC_BIT_RESET;
      cause_energy <= `PMC_BIT_RESET;
    end else begin
      cause_frame <= next_cause_frame;
      cause_energy <= next_cause_energy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake indication

  // Drops once no cause is left set together with its enable
  assign wake_level = (cause_frame && wake_frame_enable)
                   || (cause_energy && energy_detect_enable);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      level_d <= 1'b0;
    end else begin
      level_d <= wake_level;
    end
  end

  assign pulse_start = wake_level && !level_d && wake_pulse_select;

  pmc_cycle_timer #(
    .W(`PMC_TIMER_W)
  ) u_pulse_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .start(pulse_start),
    .load(`PMC_TIMER_W'(PULSE_CYCLES - 1)),
    .busy(pulse_busy),
    .done()
  );

  // Pulse for the timed window or steady level
  assign wake_active = wake_level
                    && (!wake_pulse_select || pulse_start || pulse_busy);

  assign pin_active = wake_active && wake_output_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Wake pin and interrupt

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wake_event_output <= 1'b0;
      wake_event_oe <= 1'b0;
    end else if (wake_output_drive_type) begin
      wake_event_oe <= 1'b1;
      wake_event_output <= wake_output_polarity ? pin_active : !pin_active;
    end else begin
      wake_event_oe <= pin_active;
      wake_event_output <= 1'b0;
    end
  end

  // Interrupt ignores the pin enable
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wake_event_interrupt <= 1'b0;
    end else begin
      wake_event_interrupt <= wake_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status outputs

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      power_state <= `PMC_STATE_RESET;
      device_ready <= 1'b0;
    end else begin
      power_state <= state;
      device_ready <= ready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  always_comb begin
    ctrl_value = '0;
    ctrl_value[`PMC_STATE_MSB:`PMC_STATE_LSB] = state;
    ctrl_value[`PMC_PHY_RESET_TRIGGER_BIT] = phy_reset_trigger;
    ctrl_value[`PMC_FRAME_EN_BIT] = wake_frame_enable;
    ctrl_value[`PMC_ENERGY_EN_BIT] = energy_detect_enable;
    ctrl_value[`PMC_DRIVE_TYPE_BIT] = wake_output_drive_type;
    ctrl_value[`PMC_CAUSE_FRAME_BIT] = cause_frame;
    ctrl_value[`PMC_CAUSE_ENERGY_BIT] = cause_energy;
    ctrl_value[`PMC_PULSE_SEL_BIT] = wake_pulse_select;
    ctrl_value[`PMC_POLARITY_BIT] = wake_output_polarity;
    ctrl_value[`PMC_OUT_EN_BIT] = wake_output_enable;
    ctrl_value[`PMC_READY_BIT] = ready;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd && hit_ctrl) begin
      reg_rdata <= ctrl_value;
    end else if (reg_rd && hit_endian && ready) begin
      reg_rdata <= `PMC_ENDIAN_PATTERN;
    end else if (reg_rd) begin
      reg_rdata <= '0;
    end
  end

endmodule // pmc_top

// >>> tb/pmc_checker.sv
// Port checker for the power control block
`timescale 1ns/100ps
module pmc_checker #(
  parameter int unsigned PHY_RESET_CYCLES = 20,
  parameter int unsigned PULSE_CYCLES = 30,
  parameter int unsigned STABLE_CYCLES = 10
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic wake_frame_source,
  input wire logic energy_source,
  input wire logic wake_event_output,
  input wire logic wake_event_oe,
  input wire logic wake_event_interrupt,
  input wire logic phy_reset_n,
  input wire logic [1:0] power_state,
  input wire logic device_ready
);
  localparam int STB = STABLE_CYCLES + 4;
  logic [31:0] low_cnt;
  wire ctrl_rd = reg_rd && reg_addr == 8'h84;
  always_ff @(posedge mclk) begin
    if (!rst_n || phy_reset_n) begin
      low_cnt <= 32'h0000_0000;
    end else begin
      low_cnt <= low_cnt + 32'h0000_0001;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////////
  property p_phy_hold;
    $rose(phy_reset_n) |-> low_cnt == PHY_RESET_CYCLES + 1;
  endproperty
  a_phy_hold: assert property (p_phy_hold) else $error("phy reset length wrong");
  property p_phy_bit;
    !phy_reset_n && ctrl_rd |=> reg_rdata[10];
  endproperty
  a_phy_bit: assert property (p_phy_bit) else $error("phy bit low in reset");
  property p_state_legal;
    power_state != 2'b11;
  endproperty
  a_state_legal: assert property (p_state_legal) else $error("reserved state");
  property p_ready_bit;
    ctrl_rd |=> reg_rdata[0] == device_ready;
  endproperty
  a_ready_bit: assert property (p_ready_bit) else $error("ready bit mismatch");
  property p_state_read;
    ctrl_rd |=> reg_rdata[13:12] == power_state;
  endproperty
  a_state_read: assert property (p_state_read) else $error("state read mismatch");
  property p_ready_normal;
    $rose(device_ready) |-> power_state == 2'b00;
  endproperty
  a_ready_normal: assert property (p_ready_normal) else $error("ready outside normal");
  property p_wake_ready;
    $changed(power_state) && power_state == 2'b00 |-> !device_ready ##[1:STB] device_ready;
  endproperty
  a_wake_ready: assert property (p_wake_ready) else $error("ready not regained");
  property p_endian_wake;
    reg_wr && reg_addr == 8'h64 && power_state != 2'b00 |-> ##[1:2] power_state == 2'b00;
  endproperty
  a_endian_wake: assert property (p_endian_wake) else $error("no endian wake");
  property p_od_out;
    wake_event_output |-> wake_event_oe;
  endproperty
  a_od_out: assert property (p_od_out) else $error("pin high undriven");
  property p_int_cause;
    $rose(wake_event_interrupt) |->
      $past(wake_frame_source, 2) || $past(energy_source, 2) || $past(reg_wr, 2);
  endproperty
  a_int_cause: assert property (p_int_cause) else $error("interrupt uncaused");
  c_phy: cover property ($rose(phy_reset_n));
  c_int: cover property ($rose(wake_event_interrupt));
  c_endian: cover property (reg_wr && reg_addr == 8'h64 && power_state != 2'b00);
endmodule // pmc_checker
bind pmc_top pmc_checker #(
  .PHY_RESET_CYCLES(PHY_RESET_CYCLES),
  .PULSE_CYCLES(PULSE_CYCLES),
  .STABLE_CYCLES(STABLE_CYCLES)
) u_chk (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .wake_frame_source(wake_frame_source), .energy_source(energy_source),
  .wake_event_output(wake_event_output), .wake_event_oe(wake_event_oe),
  .wake_event_interrupt(wake_event_interrupt), .phy_reset_n(phy_reset_n),
  .power_state(power_state), .device_ready(device_ready));

// >>> tb/pmc_host.sv
// Host processor model on the register bus
`timescale 1ns/100ps
module pmc_host (
  input wire logic mclk,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Callers never pass the reserved state code
  task automatic wr(input logic [7:0] a, input logic [31:0] dt);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= dt;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~dt;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] dt);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge mclk);
    dt = reg_rdata;
  endtask
endmodule // pmc_host

// >>> tb/tb.sv
// Testbench for the power control block
`timescale 1ns/100ps
`include "pmc_defs.svh"
module tb;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic fsrc = 1'b0;
  logic esrc = 1'b0;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic [31:0] d;
  logic reg_wr;
  logic reg_rd;
  logic pin;
  logic oe;
  logic wint;
  logic phy_n;
  logic ready;
  logic [1:0] pst;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  always #2 mclk = ~mclk;
  pmc_host host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  pmc_top #(.PHY_RESET_CYCLES(20), .PULSE_CYCLES(30), .STABLE_CYCLES(10)) DUT (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .wake_frame_source(fsrc), .energy_source(esrc), .wake_event_output(pin),
    .wake_event_oe(oe), .wake_event_interrupt(wint), .phy_reset_n(phy_n),
    .power_state(pst), .device_ready(ready));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic summarize();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wready();
    for (int i = 0; i < 100 && ready !== 1'b1; i++) @(posedge mclk);
    chk("ready", 1, ready);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    host.rd(a, d);
    chk("rdata", e, d);
  endtask
  task automatic pulse_src(input logic en);
    @(posedge mclk);
    fsrc <= en;
    esrc <= !en;
    @(posedge mclk);
    fsrc <= 1'b0;
    esrc <= 1'b0;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    @(posedge mclk);
    chk("ready", 0, ready);
    wready();
    host.wr(8'h84, 32'h0000_0346);
    rchk(8'h84, 32'h0000_0001);
    host.wr(8'h84, 32'h0000_0346);
    rchk(8'h84, 32'h0000_0347);
  endtask
  task automatic t_phy();
    host.wr(8'h84, 32'h0000_0746);
    @(posedge mclk);
    chk("phy_n", 0, phy_n);
    rchk(8'h84, 32'h0000_0747);
    host.wr(8'h84, 32'h0000_0746);
    rchk(8'h84, 32'h0000_0747);
    for (int i = 0; i < 100 && phy_n !== 1'b1; i++) @(posedge mclk);
    rchk(8'h84, 32'h0000_0347);
  endtask
  task automatic t_frame();
    host.wr(8'h84, 32'h0000_1346);
    repeat (2) @(posedge mclk);
    chk("state", 1, pst);
    rchk(8'h84, 32'h0000_1346);
    pulse_src(1'b1);
    repeat (3) @(posedge mclk);
    chk("state", 0, pst);
    chk("int", 1, wint);
    chk("pin", 1, pin);
    wready();
    rchk(8'h84, 32'h0000_0367);
    fsrc <= 1'b1;
    host.wr(8'h84, 32'h0000_0366);
    rchk(8'h84, 32'h0000_0367);
    fsrc <= 1'b0;
    host.wr(8'h84, 32'h0000_0366);
    repeat (3) @(posedge mclk);
    chk("pin", 0, pin);
    rchk(8'h84, 32'h0000_0347);
  endtask
  task automatic t_energy();
    int n;
    host.wr(8'h84, 32'h0000_230e);
    repeat (2) @(posedge mclk);
    chk("state", 2, pst);
    pulse_src(1'b0);
    for (int i = 0; i < 20 && oe !== 1'b1; i++) @(posedge mclk);
    chk("int", 1, wint);
    for (n = 0; n < 200 && oe === 1'b1; n++) begin
      chk("pin", 0, pin);
      @(posedge mclk);
    end
    chk("pulse", 30, n);
    wready();
    rchk(8'h84, 32'h0000_031f);
    host.wr(8'h84, 32'h0000_020e);
    repeat (3) @(posedge mclk);
    chk("int", 0, wint);
    host.wr(8'h84, 32'h0000_021e);
    rchk(8'h84, 32'h0000_020f);
  endtask
  task automatic t_endian();
    host.wr(8'h84, 32'h0000_1240);
    host.wr(8'h64, 32'h0000_0000);
    repeat (2) @(posedge mclk);
    chk("state", 0, pst);
    wready();
    rchk(8'h64, `PMC_ENDIAN_PATTERN);
    rchk(8'h90, 32'h0000_0000);
    pulse_src(1'b1);
    repeat (3) @(posedge mclk);
    chk("int", 1, wint);
    chk("pin", 1, pin);
  endtask
  //////////////////////////////////////////////////////////////////////////
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_phy();
    t_frame();
    t_energy();
    t_endian();
    summarize();
  end
endmodule // tb
